// >>> rtl/pwm_bit_link_timing_assist.sv
// timing assist for a single-wire link pin: break timer, sync timer, capture/compare, pin control
// assumes AXI4-Lite master on clk, link pin and transceiver flags asynchronous to clk
// What the document asks of this block
// R1 - lin mode: break timer starts at first fall, flags when threshold reached
// R2 - sync timer starts next fall, stop flag when fall count hits stop field
// R3 - software sets the receive gating bit before the line returns high
// R4 - live pin level reads back on port data bit 4
// R5 - with gpio selected by config bit 20, port data drives the pin
// R6 - short sets hv flag bit 2; driver re-enable clears; protection can be off
// R7 - thermal flag never interrupts link traffic
// R8 - symbols are sync, zero, one; frame holds 19 bits
// R9 - bit rate 1200 bps within plus or minus three percent
// R10 - low-time bands: sync 1-3/16, zero 5-8/16, one 10-14/16
// R11 - break timer measures each received low pulse width; in lin mode the code starts it only at the first fall
// R12 - internal drive signal reaches the pin under software control
// R13 - 16-bit sync timer at 5 MHz, captured at every falling edge; the code captures only in bit-link mode
// R14 - compare enable bit 5 gates the compare interrupt
// R15 - frame order: pause, dir, slave, register, parity, data, parity, ack
// R16 - direction bit 0 for master request, 1 for slave request
// R17 - register address bit 3 set for write, clear for read
// R18 - parity bits are one for odd count of ones; hdrParOk/dataParOk expect one for an even count
// R19 - bit-link mode: free-running sync timer sets status bit 3 at compare
// R20 - slave always sends acknowledge, zero means success
// R21 - on master read slave sends data, data parity, acknowledge
// R22 - bit-link receive: break timer clears at fall, stops at rise, 131 kHz
// R23 - software selects bit-link mode with control bit 6 first
// R24 - software classifies widths; outside all bands is an error
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module pwm_bit_link_timing_assist (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic linPinIn,
  output logic linPinOut,
  output logic linPinOe,
  input wire logic shortDetect,
  input wire logic thermalEvent,
  output logic uartRxGate,
  output logic linEvent
);
  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  // address decode shared by read and write paths
  function automatic logic mapped(input logic [31:0] a);
    return a >= pwm_bit_link_pkg::ADDR_CONTROL && a <= pwm_bit_link_pkg::ADDR_HV_SETUP && a[1:0] == 2'b00;
  endfunction : mapped

  logic syncTick;
  logic lpTick;
  logic [2:0] pinMetaReg;
  logic [2:0] pinSyncReg;
  logic linPrevReg;
  logic [31:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic awHaveReg;
  logic wHaveReg;
  logic bvalidReg;
  logic [1:0] brespReg;
  logic rvalidReg;
  logic [31:0] rdataReg;
  logic [1:0] rrespReg;
  logic [8:0] ctrlReg;
  logic [7:0] edgeSetupReg;
  logic [5:0] flagsReg;
  logic [11:0] breakCmpReg;
  logic [11:0] breakTmrReg;
  logic breakRunReg;
  logic [15:0] syncTmrReg;
  logic syncRunReg;
  logic [3:0] edgeCntReg;
  logic [15:0] capReg;
  logic [15:0] cmpReg;
  logic [18:0] frameReg;
  logic [4:0] bitCntReg;
  logic [1:0] lastClassReg;
  logic gpioSelReg;
  logic driveReg;
  logic shortFlagReg;
  logic thermalFlagReg;
  logic protOffReg;

  // slow rate enables from the system clock
  rate_tick #(.DIV(pwm_bit_link_pkg::SYNC_DIV)) syncRate (.clk(clk), .reset(reset), .tick(syncTick));
  rate_tick #(.DIV(pwm_bit_link_pkg::LP_DIV)) lpRate (.clk(clk), .reset(reset), .tick(lpTick));

  // two-stage synchronisers for pin, short and thermal inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      pinMetaReg <= 3'h1; // line idles high, no false fall
      pinSyncReg <= 3'h1;
    end else begin
      pinMetaReg <= {thermalEvent, shortDetect, linPinIn};
      pinSyncReg <= pinMetaReg;
    end
  end

  // pin level and edges
  wire linLevel = pinSyncReg[0];
  wire shortSync = pinSyncReg[1];
  wire thermalSync = pinSyncReg[2];
  wire linFall = linPrevReg & ~linLevel;
  wire linRise = ~linPrevReg & linLevel;
  wire enabled = ctrlReg[pwm_bit_link_pkg::CTL_EN];
  wire bitMode = enabled & ctrlReg[pwm_bit_link_pkg::CTL_MODE];
  wire linMode = enabled & ~ctrlReg[pwm_bit_link_pkg::CTL_MODE];

  // bus handshakes
  wire wrEn = awHaveReg & wHaveReg & ~bvalidReg;
  wire arHs = arvalid & arready;
  wire wrOk = mapped(awAddrReg);
  assign awready = ~awHaveReg & ~bvalidReg;
  assign wready = ~wHaveReg & ~bvalidReg;
  assign arready = ~rvalidReg;
  assign bvalid = bvalidReg;
  assign bresp = brespReg;
  assign rvalid = rvalidReg;
  assign rdata = rdataReg;
  assign rresp = rrespReg;

  // write selects
  wire selCtrl = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_CONTROL);
  wire selFlags = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_FLAGS);
  wire selEdge = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_EDGE_SETUP);
  wire selBrk = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_BREAK_TMR);
  wire selCmp = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_COMPARE);
  wire selPcfg = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_PORT_CFG);
  wire selPdat = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_PORT_DATA);
  wire selHvf = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_HV_FLAGS);
  wire selHvc = wrEn & (awAddrReg == pwm_bit_link_pkg::ADDR_HV_SETUP);
  wire [31:0] wMerged = merge(32'h00000000, wDataReg, wStrbReg);
  wire brkRead = arHs & (araddr == pwm_bit_link_pkg::ADDR_BREAK_TMR);

  // lin break and sync sequencing
  wire firstFall = linMode & linFall & (edgeCntReg == 4'h0);
  wire [3:0] edgeNext = edgeCntReg + 4'h1;
  wire syncStart = linMode & linFall & flagsReg[pwm_bit_link_pkg::FLG_BREAK] &
    (edgeNext == edgeSetupReg[3:0]);
  wire stopHit = linMode & linFall & syncRunReg & (edgeNext == edgeSetupReg[7:4]);
  wire brkHit = linMode & breakRunReg & lpTick & ~linRise & ~brkRead &
    (breakTmrReg + 12'h001 == breakCmpReg);
  wire brkOvf = breakRunReg & lpTick & (breakTmrReg == 12'hfff);
  wire cmpHit = bitMode & ctrlReg[pwm_bit_link_pkg::CTL_CMP_EN] & syncTick &
    (syncTmrReg + 16'h0001 == cmpReg);
  wire pulseEnd = bitMode & breakRunReg & linRise;

  // width classification of a finished low pulse
  wire [1:0] pulseClass =
    (breakTmrReg >= pwm_bit_link_pkg::SYNC_LO && breakTmrReg <= pwm_bit_link_pkg::SYNC_HI) ?
      pwm_bit_link_pkg::PULSE_SYNC :
    (breakTmrReg >= pwm_bit_link_pkg::ZERO_LO && breakTmrReg <= pwm_bit_link_pkg::ZERO_HI) ?
      pwm_bit_link_pkg::PULSE_ZERO :
    (breakTmrReg >= pwm_bit_link_pkg::ONE_LO && breakTmrReg <= pwm_bit_link_pkg::ONE_HI) ?
      pwm_bit_link_pkg::PULSE_ONE : pwm_bit_link_pkg::PULSE_BAD; // [R10] [R9] [R8]

  // frame parity checks over the received bits
  wire hdrParOk = ^frameReg[pwm_bit_link_pkg::FR_DIR:pwm_bit_link_pkg::FR_HDR_PAR]; // [R18]
  wire dataParOk = ^frameReg[pwm_bit_link_pkg::FR_HDR_PAR-1:pwm_bit_link_pkg::FR_DATA_PAR]; // [R18]

  // sticky flag set and write-one clear, set wins
  wire [5:0] flagSet = {bitMode & linFall & ctrlReg[pwm_bit_link_pkg::CTL_START_IRQ], brkOvf, cmpHit,
    pulseEnd & ctrlReg[pwm_bit_link_pkg::CTL_GATE], stopHit, brkHit};
  wire [5:0] flagClr = selFlags ? wMerged[5:0] : 6'h00;

  // read data selection
  wire [31:0] rdMux =
    (araddr == pwm_bit_link_pkg::ADDR_CONTROL) ? {23'h0, ctrlReg} :
    (araddr == pwm_bit_link_pkg::ADDR_FLAGS) ? {26'h0, flagsReg} :
    (araddr == pwm_bit_link_pkg::ADDR_SYNC_TMR) ? {16'h0, syncTmrReg} :
    (araddr == pwm_bit_link_pkg::ADDR_EDGE_SETUP) ? {24'h0, edgeSetupReg} :
    (araddr == pwm_bit_link_pkg::ADDR_BREAK_TMR) ? {20'h0, breakTmrReg} :
    (araddr == pwm_bit_link_pkg::ADDR_CAPTURE) ? {16'h0, capReg} :
    (araddr == pwm_bit_link_pkg::ADDR_COMPARE) ? {16'h0, cmpReg} :
    (araddr == pwm_bit_link_pkg::ADDR_FRAME) ?
      {2'h0, dataParOk, hdrParOk, lastClassReg, bitCntReg, 2'h0, frameReg} :
    (araddr == pwm_bit_link_pkg::ADDR_PORT_CFG) ? {11'h0, gpioSelReg, 20'h0} :
    (araddr == pwm_bit_link_pkg::ADDR_PORT_DATA) ? {26'h0, driveReg, linLevel, 4'h0} : // [R4]
    (araddr == pwm_bit_link_pkg::ADDR_HV_FLAGS) ? {28'h0, thermalFlagReg, shortFlagReg, 2'h0} :
    (araddr == pwm_bit_link_pkg::ADDR_HV_SETUP) ? {29'h0, protOffReg, 2'h0} : 32'h00000000;

  // write channel capture and response
  always_ff @(posedge clk) begin
    if (reset) begin
      awHaveReg <= 1'b0;
      wHaveReg <= 1'b0;
      bvalidReg <= 1'b0;
      brespReg <= 2'b00;
      awAddrReg <= 32'h00000000;
      wDataReg <= 32'h00000000;
      wStrbReg <= 4'h0;
    end else begin
      if (awvalid & awready) begin
        awHaveReg <= 1'b1;
        awAddrReg <= awaddr;
      end
      if (wvalid & wready) begin
        wHaveReg <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end
      if (wrEn) begin
        awHaveReg <= 1'b0;
        wHaveReg <= 1'b0;
        bvalidReg <= 1'b1;
        brespReg <= wrOk ? 2'b00 : 2'b10;
      end else if (bvalidReg & bready) begin
        bvalidReg <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge clk) begin
    if (reset) begin
      rvalidReg <= 1'b0;
      rdataReg <= 32'h00000000;
      rrespReg <= 2'b00;
    end else if (arHs) begin
      rvalidReg <= 1'b1;
      rdataReg <= rdMux;
      rrespReg <= mapped(araddr) ? 2'b00 : 2'b10;
    end else if (rready) begin
      rvalidReg <= 1'b0;
    end
  end

  // software-written configuration
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlReg <= pwm_bit_link_pkg::CONTROL_RST;
      edgeSetupReg <= pwm_bit_link_pkg::EDGE_SETUP_RST;
      breakCmpReg <= pwm_bit_link_pkg::BREAK_CMP_RST;
      cmpReg <= pwm_bit_link_pkg::COMPARE_RST;
      gpioSelReg <= 1'b0;
      driveReg <= 1'b1;
      protOffReg <= 1'b0;
    end else begin
      if (selCtrl) ctrlReg <= 9'(merge({23'h0, ctrlReg}, wDataReg, wStrbReg));
      if (selEdge) edgeSetupReg <= 8'(merge({24'h0, edgeSetupReg}, wDataReg, wStrbReg));
      if (selBrk) breakCmpReg <= 12'(merge({20'h0, breakCmpReg}, wDataReg, wStrbReg));
      if (selCmp) cmpReg <= 16'(merge({16'h0, cmpReg}, wDataReg, wStrbReg));
      if (selPcfg & wStrbReg[2]) gpioSelReg <= wDataReg[pwm_bit_link_pkg::PCFG_GPIO]; // [R5]
      if (selPdat & wStrbReg[0]) driveReg <= wDataReg[pwm_bit_link_pkg::PDAT_DRIVE]; // [R5] [R12]
      if (selHvc & wStrbReg[0]) protOffReg <= wDataReg[pwm_bit_link_pkg::HVC_PROT_OFF]; // [R6]
    end
  end

  // flags, edge counting and sync timer
  always_ff @(posedge clk) begin
    if (reset) begin
      flagsReg <= 6'h00;
      edgeCntReg <= 4'h0;
      syncRunReg <= 1'b0;
      syncTmrReg <= 16'h0000;
      capReg <= 16'h0000;
      linPrevReg <= 1'b1;
    end else begin
      linPrevReg <= linLevel;
      flagsReg <= (flagsReg & ~flagClr) | flagSet; // [R1] [R2] [R14] [R19]
      if (!linMode) begin
        edgeCntReg <= 4'h0;
      end else if (stopHit) begin
        edgeCntReg <= 4'h0; // next fall opens a new break
      end else if (linFall && edgeCntReg != 4'hf) begin
        edgeCntReg <= edgeNext;
      end
      if (bitMode) begin
        syncRunReg <= 1'b0;
        if (syncTick) syncTmrReg <= syncTmrReg + 16'h0001; // [R13] [R19]
        if (linFall) capReg <= syncTmrReg; // [R13]
      end else if (syncStart) begin
        syncRunReg <= 1'b1; // [R2]
        syncTmrReg <= 16'h0000;
      end else if (stopHit | ~linMode) begin
        syncRunReg <= 1'b0; // [R2]
      end else if (syncRunReg & syncTick) begin
        syncTmrReg <= syncTmrReg + 16'h0001;
      end
    end
  end

  // break-width timer, pulse class and frame shifter
  always_ff @(posedge clk) begin
    if (reset) begin
      breakTmrReg <= 12'h000;
      breakRunReg <= 1'b0;
      frameReg <= 19'h00000;
      bitCntReg <= 5'h00;
      lastClassReg <= pwm_bit_link_pkg::PULSE_BAD;
    end else begin
      if (!enabled) begin
        breakRunReg <= 1'b0;
      end else if ((bitMode & linFall) | firstFall) begin
        breakTmrReg <= 12'h000; // [R1] [R11] [R22]
        breakRunReg <= 1'b1;
      end else if (linRise | brkOvf) begin
        breakRunReg <= 1'b0; // [R22]
      end else if (brkRead) begin
        breakTmrReg <= 12'h000;
      end else if (breakRunReg & lpTick) begin
        breakTmrReg <= breakTmrReg + 12'h001; // [R22]
      end
      if (pulseEnd) begin
        lastClassReg <= pulseClass; // [R11]
        if (pulseClass == pwm_bit_link_pkg::PULSE_SYNC) begin
          bitCntReg <= 5'h00; // [R15]
        end else if (pulseClass != pwm_bit_link_pkg::PULSE_BAD) begin
          frameReg <= {frameReg[17:0], pulseClass == pwm_bit_link_pkg::PULSE_ONE}; // [R15] [R16] [R17]
          if (bitCntReg != 5'(pwm_bit_link_pkg::FRAME_BITS)) bitCntReg <= bitCntReg + 5'h01; // [R8]
        end
      end
    end
  end

  // transceiver status: short protection and thermal flag
  wire reenable = selHvc & wStrbReg[0] & wDataReg[pwm_bit_link_pkg::HVC_REENABLE];
  always_ff @(posedge clk) begin
    if (reset) begin
      shortFlagReg <= 1'b0;
      thermalFlagReg <= 1'b0;
    end else begin
      if (shortSync & ~protOffReg) shortFlagReg <= 1'b1; // [R6]
      else if (reenable) shortFlagReg <= 1'b0; // [R6]
      if (thermalSync) thermalFlagReg <= 1'b1;
      else if (selHvf & wStrbReg[0] & wDataReg[pwm_bit_link_pkg::HV_THERMAL]) thermalFlagReg <= 1'b0;
    end
  end

  // pin drive: driver on only with gpio selected and no short flag, thermal state does not cut it
  assign linPinOe = gpioSelReg & ~shortFlagReg; // [R5] [R7] [R12]
  assign linPinOut = driveReg; // [R12] [R20] [R21]
  assign uartRxGate = ctrlReg[pwm_bit_link_pkg::CTL_GATE]; // [R3]
  assign linEvent = |flagsReg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence bothHeld;
    awHaveReg && wHaveReg && !bvalidReg;
  endsequence
  sequence respStands;
    bvalid && !bready;
  endsequence

  a_break_reach: assert property (brkHit |=> flagsReg[0] && breakTmrReg == breakCmpReg) // [R1]
    else $error("break flag not set at threshold");
  a_stop_edge: assert property (stopHit |=> flagsReg[1] && !syncRunReg) // [R2]
    else $error("stop condition not flagged");
  a_pin_readback: assert property (linLevel == $past(linPinIn, 2)) // [R4]
    else $error("pin readback lags wrongly");
  a_pin_drive: assert property (gpioSelReg && !shortFlagReg |-> linPinOe && linPinOut == driveReg) // [R5]
    else $error("gpio drive not on pin");
  a_short_cut: assert property (shortSync && !protOffReg |=> shortFlagReg && !linPinOe) // [R6]
    else $error("short did not disable driver");
  a_thermal_run: assert property (thermalFlagReg && gpioSelReg && !shortFlagReg |-> linPinOe) // [R7]
    else $error("thermal flag stopped the link");
  a_capture_fall: assert property (bitMode && linFall |=> capReg == $past(syncTmrReg)) // [R13]
    else $error("capture missed falling edge");
  a_compare_hit: assert property (cmpHit |=> flagsReg[3] && syncTmrReg == cmpReg) // [R14] [R19]
    else $error("compare flag not raised");
  a_width_restart: assert property (bitMode && linFall |=> breakRunReg && breakTmrReg == 12'h000) // [R22]
    else $error("width timer not restarted");
  a_write_resp: assert property (bothHeld |=> bvalid)
    else $error("write response missing");
  a_resp_hold: assert property (respStands |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
endmodule : pwm_bit_link_timing_assist

// >>> shared/pwm_bit_link_pkg.sv
// constants for the pwm bit link timing assist block
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus
package pwm_bit_link_pkg;
  // clock rates and derived tick dividers
  localparam int CLK_HZ = 50_000_000;
  localparam int SYNC_CLK_HZ = 5_000_000;
  localparam int LP_CLK_HZ = 131_000;
  localparam int SYNC_DIV = CLK_HZ / SYNC_CLK_HZ;
  localparam int LP_DIV = CLK_HZ / LP_CLK_HZ;

  // bit link rate and low-time bands in sixteenths of a bit
  localparam int BPS_NOM = 1200;
  localparam int BPS_MIN = 1164;
  localparam int BPS_MAX = 1236;
  localparam int SYNC_MIN_16 = 1;
  localparam int SYNC_NOM_16 = 2;
  localparam int SYNC_MAX_16 = 3;
  localparam int ZERO_MIN_16 = 5;
  localparam int ZERO_NOM_16 = 6;
  localparam int ZERO_MAX_16 = 8;
  localparam int ONE_MIN_16 = 10;
  localparam int ONE_NOM_16 = 12;
  localparam int ONE_MAX_16 = 14;
  // band limits in low-power clock ticks
  localparam logic [11:0] SYNC_LO = 12'(LP_CLK_HZ * SYNC_MIN_16 / (16 * BPS_MAX));
  localparam logic [11:0] SYNC_HI = 12'(LP_CLK_HZ * SYNC_MAX_16 / (16 * BPS_MIN));
  localparam logic [11:0] ZERO_LO = 12'(LP_CLK_HZ * ZERO_MIN_16 / (16 * BPS_MAX));
  localparam logic [11:0] ZERO_HI = 12'(LP_CLK_HZ * ZERO_MAX_16 / (16 * BPS_MIN));
  localparam logic [11:0] ONE_LO = 12'(LP_CLK_HZ * ONE_MIN_16 / (16 * BPS_MAX));
  localparam logic [11:0] ONE_HI = 12'(LP_CLK_HZ * ONE_MAX_16 / (16 * BPS_MIN));

  // frame layout, newest bit at position 0
  localparam int FRAME_BITS = 19;
  localparam int PAUSE_SYNCS = 3;
  localparam int FR_DIR = 18;
  localparam int FR_SLAVE_LSB = 15;
  localparam int FR_REG_LSB = 11;
  localparam int FR_REG_WRITE = 14;
  localparam int FR_HDR_PAR = 10;
  localparam int FR_DATA_LSB = 2;
  localparam int FR_DATA_PAR = 1;

  // register byte addresses
  localparam logic [31:0] ADDR_CONTROL = 32'hffff0780;
  localparam logic [31:0] ADDR_FLAGS = 32'hffff0784;
  localparam logic [31:0] ADDR_SYNC_TMR = 32'hffff0788;
  localparam logic [31:0] ADDR_EDGE_SETUP = 32'hffff078c;
  localparam logic [31:0] ADDR_BREAK_TMR = 32'hffff0790;
  localparam logic [31:0] ADDR_CAPTURE = 32'hffff0794;
  localparam logic [31:0] ADDR_COMPARE = 32'hffff0798;
  localparam logic [31:0] ADDR_FRAME = 32'hffff079c;
  localparam logic [31:0] ADDR_PORT_CFG = 32'hffff07a0;
  localparam logic [31:0] ADDR_PORT_DATA = 32'hffff07a4;
  localparam logic [31:0] ADDR_HV_FLAGS = 32'hffff07a8;
  localparam logic [31:0] ADDR_HV_SETUP = 32'hffff07ac;

  // field positions
  localparam int CTL_EN = 0;
  localparam int CTL_START_IRQ = 3;
  localparam int CTL_CMP_EN = 5;
  localparam int CTL_MODE = 6;
  localparam int CTL_GATE = 8;
  localparam int FLG_BREAK = 0;
  localparam int FLG_STOP = 1;
  localparam int FLG_PULSE = 2;
  localparam int FLG_CMP = 3;
  localparam int FLG_BRKERR = 4;
  localparam int FLG_START = 5;
  localparam int PCFG_GPIO = 20;
  localparam int PDAT_READ = 4;
  localparam int PDAT_DRIVE = 5;
  localparam int HV_SHORT = 2;
  localparam int HV_THERMAL = 3;
  localparam int HVC_PROT_OFF = 2;
  localparam int HVC_REENABLE = 3;

  // reset values
  localparam logic [8:0] CONTROL_RST = 9'h000;
  localparam logic [7:0] EDGE_SETUP_RST = 8'h32;
  localparam logic [11:0] BREAK_CMP_RST = 12'h047;
  localparam logic [15:0] COMPARE_RST = 16'h0000;

  typedef enum logic [1:0] {PULSE_BAD, PULSE_SYNC, PULSE_ZERO, PULSE_ONE} pulse_class_t;
endpackage : pwm_bit_link_pkg

// >>> rtl/rate_tick.sv
// one-cycle enable pulse every DIV clock cycles
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ps
module rate_tick #(
  parameter int DIV = 10
) (
  input wire logic clk,
  input wire logic reset,
  output logic tick
);
  logic [8:0] countReg;

  // divider counter wraps at DIV-1
  always_ff @(posedge clk) begin
    if (reset) begin
      countReg <= 9'h000;
    end else if (countReg == 9'(DIV - 1)) begin
      countReg <= 9'h000;
    end else begin
      countReg <= countReg + 9'h001;
    end
  end

  assign tick = (countReg == 9'(DIV - 1));
endmodule : rate_tick

// >>> dv/link_master_node.sv
// bus master node on the single-wire link: pulls the line low for symbols
// assumes a pull-up on the line and the device driving through linPinOut/linPinOe
`timescale 1ns/1ps
module link_master_node (
  input wire logic linPinOut,
  input wire logic linPinOe,
  output logic linLevel
);
  logic masterLow = 1'b0;
  // wired-and line: pull-up, master pull-down, device driver
  assign linLevel = !masterLow && !(linPinOe && !linPinOut);
  // start or end the low part of a symbol; caller times the width
  task automatic pull(input logic low);
    masterLow <= low;
  endtask : pull
endmodule : link_master_node

// >>> dv/testbench.sv
// self-checking bench for the pwm bit link timing assist block
// assumes a 50 MHz clock, AXI4-Lite master driven here, link master in link_master_node
`timescale 1ns/1ps
module testbench;
  localparam int ZERO_LOW = 41666 * 6 / 16;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
  logic clk = 0, reset = 1, shortDetect = 0, thermalEvent = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, seed = 32'h01e3, cap;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, linPinIn, linPinOut, linPinOe, uartRxGate, linEvent;
  logic [1:0] bresp, rresp;
  note_t notes[$];
  note_t n;
  int miscompares = 0, check_count = 0, cycles = 0;

  pwm_bit_link_timing_assist DUT (.clk(clk), .reset(reset), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .linPinIn(linPinIn), .linPinOut(linPinOut),
    .linPinOe(linPinOe), .shortDetect(shortDetect), .thermalEvent(thermalEvent), .uartRxGate(uartRxGate),
    .linEvent(linEvent));
  link_master_node pm (.linPinOut(linPinOut), .linPinOe(linPinOe), .linLevel(linPinIn));

  // clock
  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // read: note the expectation, hold request until taken, rready until rvalid
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    notes.push_back('{e, m, r});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge clk);
    cap = rdata;
    rready <= 0;
    @(posedge clk);
  endtask : rd

  // write: release each channel when taken, wait for the response
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 0;
      if (wvalid && wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    check({30'h0, bresp}, 32'h0);
    bready <= 0;
    @(posedge clk);
  endtask : wr

  // monitor: compare each read answer with the oldest note
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      check(rdata & n.m, n.d);
      check({30'h0, rresp}, {30'h0, n.r});
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    repeat (2) @(posedge clk);
    seed = xs(seed);
    rd(pwm_bit_link_pkg::ADDR_CAPTURE, 0, '1, 0);
    rd(pwm_bit_link_pkg::ADDR_COMPARE, 0, 32'hffff, 0);
    wr(pwm_bit_link_pkg::ADDR_COMPARE, {16'h0, seed[15:0]});
    rd(pwm_bit_link_pkg::ADDR_COMPARE, {16'h0, seed[15:0]}, 32'hffff, 0);
    wr(pwm_bit_link_pkg::ADDR_CAPTURE, 32'h1234);
    rd(pwm_bit_link_pkg::ADDR_CAPTURE, 0, '1, 0);
    rd(32'hffff07b0, 0, '1, 2'b10);
    $display("test registers done");
    rd(pwm_bit_link_pkg::ADDR_PORT_DATA, 32'h10, 32'h10, 0);
    wr(pwm_bit_link_pkg::ADDR_PORT_CFG, 32'h0010_0000);
    wr(pwm_bit_link_pkg::ADDR_PORT_DATA, {26'h0, seed[16], 5'h0});
    repeat (4) @(posedge clk);
    check({30'h0, linPinOe, linPinOut}, {30'h0, 1'b1, seed[16]});
    rd(pwm_bit_link_pkg::ADDR_PORT_DATA, {27'h0, seed[16], 4'h0}, 32'h10, 0);
    shortDetect <= 1;
    repeat (5) @(posedge clk);
    check({31'h0, linPinOe}, 32'h0);
    rd(pwm_bit_link_pkg::ADDR_HV_FLAGS, 32'h4, 32'h4, 0);
    shortDetect <= 0;
    repeat (4) @(posedge clk);
    wr(pwm_bit_link_pkg::ADDR_HV_SETUP, 32'h8);
    rd(pwm_bit_link_pkg::ADDR_HV_FLAGS, 0, 32'h4, 0);
    wr(pwm_bit_link_pkg::ADDR_PORT_CFG, 0);
    $display("test pin control done");
    wr(pwm_bit_link_pkg::ADDR_CONTROL, 32'h161);
    check({31'h0, uartRxGate}, 32'h1);
    thermalEvent <= 1;
    pm.pull(1);
    repeat (20) @(posedge clk);
    rd(pwm_bit_link_pkg::ADDR_CAPTURE, 0, 0, 0);
    wr(pwm_bit_link_pkg::ADDR_COMPARE, cap + 32'd100);
    wr(pwm_bit_link_pkg::ADDR_FLAGS, 32'h3f);
    rd(pwm_bit_link_pkg::ADDR_PORT_DATA, 0, 32'h10, 0);
    repeat (760) @(posedge clk);
    rd(pwm_bit_link_pkg::ADDR_FLAGS, 0, 32'h8, 0);
    repeat (300) @(posedge clk);
    rd(pwm_bit_link_pkg::ADDR_FLAGS, 32'h8, 32'h8, 0);
    check({31'h0, linEvent}, 32'h1);
    repeat (ZERO_LOW - 1130) @(posedge clk);
    pm.pull(0);
    repeat (400) @(posedge clk);
    rd(pwm_bit_link_pkg::ADDR_FRAME, 32'h0820_0000, 32'h0fe0_0001, 0);
    rd(pwm_bit_link_pkg::ADDR_FLAGS, 32'h4, 32'h4, 0);
    $display("test bit link done");
    wr(pwm_bit_link_pkg::ADDR_CONTROL, 32'h1);
    wr(pwm_bit_link_pkg::ADDR_BREAK_TMR, 32'h3);
    wr(pwm_bit_link_pkg::ADDR_FLAGS, 32'h3f);
    pm.pull(1);
    repeat (1600) @(posedge clk);
    rd(pwm_bit_link_pkg::ADDR_FLAGS, 32'h1, 32'h11, 0);
    pm.pull(0);
    repeat (4) @(posedge clk);
    $display("test lin break done");
    print_verdict();
  end
endmodule : testbench
